/* spidp_checker.sv */
// Checker for the serial data port: APB timing, register read-back, idle engine, irq masking.
// Assumes it sees only the top module's ports and is bound to every spidp_top.
module spidp_checker
  import spidp_pkg::*;
#(
  parameter bit FIRST_UNIT = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [31:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ref_tick,
  input wire logic sclk_out,
  input wire logic mosi_out,
  input wire logic miso_in,
  input wire logic sclk_in,
  input wire logic mosi_in,
  input wire logic target_select_n,
  input wire logic miso_out,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [5:0] cfg_reg;
  logic [1:0] mode_reg;
  logic [3:0] en_reg;
  logic rd_done;
  assign rd_done = pready && !pwrite;
  // Shadow of the written configuration, enable and mode registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= SPIDP_CFG_RESET;
      mode_reg <= SPIDP_MODE_RESET;
      en_reg <= 4'h0;
    end else if (psel && penable && pready && pwrite) begin
      if (paddr == SPIDP_CFG_ADDR) cfg_reg <= pwdata[5:0];
      if (paddr == SPIDP_MODE_ADDR) mode_reg <= pwdata[1:0];
      if (paddr == SPIDP_INTEN_ADDR) en_reg <= pwdata[3:0];
    end
  end
  sequence s_setup;
    psel && !penable ##1 psel && penable;
  endsequence
  sequence s_answer;
    !pready ##1 pready;
  endsequence
  property p_wait_state;
    s_setup |-> s_answer;
  endproperty
  a_wait_state: assert property (p_wait_state) else $error("answer not after one wait state");
  property p_ready_in_access;
    pready |-> psel && penable;
  endproperty
  a_ready_in_access: assert property (p_ready_in_access) else $error("ready outside access");
  property p_err_with_ready;
    pslverr |-> pready && prdata == 32'h0;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("error response malformed");
  property p_upper_zero;
    rd_done |-> prdata[31:8] == 24'h0 && (paddr != SPIDP_CFG_ADDR || prdata[7:6] == 2'h0);
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("unused read bits not zero");
  property p_cfg_readback;
    rd_done && paddr == SPIDP_CFG_ADDR |-> prdata[5:0] == cfg_reg;
  endproperty
  a_cfg_readback: assert property (p_cfg_readback) else $error("configuration read-back wrong");
  property p_irq_masked;
    en_reg == 4'h0 ##1 en_reg == 4'h0 |-> !irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("irq high while all masked");
  property p_tick_edge;
    $changed(sclk_out) && $past(cfg_reg[0], 2) == cfg_reg[0] |-> $past(ref_tick) || $past(ref_tick, 2);
  endproperty
  a_tick_edge: assert property (p_tick_edge) else $error("serial clock moved without tick");
  property p_idle_mode;
    mode_reg != SPIDP_MODE_SPI |=> $stable(sclk_out) && $stable(mosi_out);
  endproperty
  a_idle_mode: assert property (p_idle_mode) else $error("serial lines moved outside SPI");
endmodule

bind spidp_top spidp_checker #(.FIRST_UNIT(FIRST_UNIT)) spidp_checker_i (.pclk, .presetn, .paddr, .psel, .penable,
  .pwrite, .pwdata, .prdata, .pready, .pslverr, .ref_tick, .sclk_out, .mosi_out, .miso_in, .sclk_in, .mosi_in,
  .target_select_n, .miso_out, .irq);

/* spidp_fifo.sv */
// Four-entry FIFO with storage that resets to zero.
// Assumes callers never rely on a push into a full FIFO being kept.
module spidp_fifo
  import spidp_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic push,
  input wire logic [W-1:0] wdata,
  input wire logic pop,
  output logic [W-1:0] rdata,
  output logic [W-1:0] peek,
  output logic full,
  output logic empty,
  output logic [SPIDP_PTR_W:0] count
);

  logic [W-1:0] mem [SPIDP_FIFO_DEPTH];
  logic [SPIDP_PTR_W-1:0] wr_reg;
  logic [SPIDP_PTR_W-1:0] rd_reg;
  logic [SPIDP_PTR_W:0] cnt_reg;
  logic do_push;
  logic do_pop;

  assign full = (cnt_reg == (SPIDP_PTR_W+1)'(SPIDP_FIFO_DEPTH));
  assign empty = (cnt_reg == '0);
  assign do_push = push & ~full;
  assign do_pop = pop & ~empty;
  assign rdata = mem[rd_reg];
  assign peek = mem[rd_reg + 1'b1];
  assign count = cnt_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < SPIDP_FIFO_DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else if (do_push) begin
      mem[wr_reg] <= wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (do_push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (do_pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (SPIDP_PTR_W+1)'(do_push) - (SPIDP_PTR_W+1)'(do_pop);
    end
  end

endmodule

/* spidp_partner.sv */
// Behavioural SPI target facing the controller; counts clock edges seen at pclk.
// Assumes the bench sets cpol before the controller's idle level moves.
module spidp_partner (
  input wire logic pclk,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic lsb,
  input wire logic [7:0] tx_byte,
  output logic miso,
  output logic [7:0] rx_byte,
  output int n_bytes
);
  timeunit 1ns;
  timeprecision 1ns;
  logic prev = 1'b0;
  int n = 0;
  int k;
  initial rx_byte = 8'h00;
  initial n_bytes = 0;
  always_comb begin
    k = cpha ? ((n == 0) ? 0 : (n - 1) / 2) : n / 2;
    miso = tx_byte[lsb ? k : 7 - k];
  end
  // Idle level changes are not edges: the first edge must leave cpol
  always @(posedge pclk) begin
    prev <= sclk;
    if (sclk != prev && (n != 0 || prev == cpol)) begin
      if ((n % 2) == int'(cpha))
        rx_byte <= lsb ? {mosi, rx_byte[7:1]} : {rx_byte[6:0], mosi};
      n <= (n + 1) % 16;
      if (n == 15) n_bytes <= n_bytes + 1;
    end
  end
endmodule

/* spidp_pkg.sv */
// Package for the serial data port and frame configuration block.
// Assumes a single APB clock domain; addresses are full byte addresses.
package spidp_pkg;

  // Register byte addresses
  localparam logic [31:0] SPIDP_DATA_ADDR = 32'h4000c03c;
  localparam logic [31:0] SPIDP_STAT_ADDR = 32'h4000c040;
  localparam logic [31:0] SPIDP_MODE_ADDR = 32'h4000c054;
  localparam logic [31:0] SPIDP_CFG_ADDR = 32'h4000c058;
  localparam logic [31:0] SPIDP_RLIN_ADDR = 32'h4000c060;
  localparam logic [31:0] SPIDP_REXP_ADDR = 32'h4000c064;
  localparam logic [31:0] SPIDP_INTST_ADDR = 32'h4000c070;
  localparam logic [31:0] SPIDP_INTEN_ADDR = 32'h4000c074;
  localparam logic [31:0] SPIDP_INTCLR_ADDR = 32'h4000c078;
  localparam logic [31:0] SPIDP_LINE_ADDR = 32'h4000c07c;

  // Frame configuration fields
  localparam int SPIDP_CFG_W = 6;
  localparam int SPIDP_CFG_RXDRV = 5;
  localparam int SPIDP_CFG_MST = 4;
  localparam int SPIDP_CFG_RPT = 3;
  localparam int SPIDP_CFG_ORD = 2;
  localparam int SPIDP_CFG_PHA = 1;
  localparam int SPIDP_CFG_POL = 0;
  localparam logic [5:0] SPIDP_CFG_RESET = 6'h00;

  // Controller function select values
  localparam logic [1:0] SPIDP_MODE_UART = 2'h1;
  localparam logic [1:0] SPIDP_MODE_SPI = 2'h2;
  localparam logic [1:0] SPIDP_MODE_RESET = 2'h0;

  // Interrupt event bit positions
  localparam int SPIDP_EV_W = 4;
  localparam int SPIDP_EV_RXOVF = 0;
  localparam int SPIDP_EV_TXUND = 1;
  localparam int SPIDP_EV_RXVAL = 2;
  localparam int SPIDP_EV_TXIDLE = 3;

  // FIFO geometry and data values
  localparam int SPIDP_FIFO_DEPTH = 4;
  localparam int SPIDP_PTR_W = 2;
  localparam logic [7:0] SPIDP_FILLER = 8'hff;
  localparam logic [7:0] SPIDP_LAST_RESET = 8'h00;
  localparam int SPIDP_DIV_W = 20;
  localparam logic [3:0] SPIDP_LAST_EDGE = 4'hf;
  localparam logic [3:0] SPIDP_PUSH_EDGE = 4'he;

  typedef enum logic {SPIDP_IDLE, SPIDP_SHIFT} spidp_state_e;

endpackage

/* spidp_top.sv */
// Serial data port, frame configuration and SPI shift engine, controller and target role.
// Assumes an APB3 master, pins synchronous to pclk, ref_tick one pulse per reference half-cycle.
// Operation
// - Data register write pushes the byte onto the transmit FIFO in order.
// - Data register read returns and removes oldest receive byte, clears overflow.
// - First unit in UART mode: data read loads next byte's error bits.
// - Controller starts on transmit data, or on receive room when receive-paced.
// - Role select bit 4 set means controller, clear means target.
// - Underrun sends 0xFF when filler select clear, last byte when set.
// - Filler sent on empty transmit source in target role.
// - Target sends filler as first byte each time select asserts.
// - Filler select change applies only when transmit FIFO empty and idle.
// - Last byte resets to 0x00 so early repeat sends zero.
// - Bit order select bit 2: 0 MSB first, 1 LSB first, both directions.
// - Phase bit 1: clear samples leading edge, set samples second edge.
// - Polarity bit 0: clear gives rising leading edge, set falling.
// - Transmit and receive FIFOs hold four bytes each.
// - Byte arriving with receive FIFO full is dropped and overflow set.
// - Controller clock divides reference by (linear+1) times two to exponential.
// - SPI active only when function select is 2.
//
// Local design decision: the APB register port.
module spidp_top
  import spidp_pkg::*;
#(
  parameter bit FIRST_UNIT = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [31:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ref_tick,
  output logic sclk_out,
  output logic mosi_out,
  input wire logic miso_in,
  input wire logic sclk_in,
  input wire logic mosi_in,
  input wire logic target_select_n,
  output logic miso_out,
  output logic irq
);

  spidp_state_e state_reg;
  logic [SPIDP_CFG_W-1:0] cfg_reg;
  logic [1:0] mode_reg;
  logic [3:0] lin_reg;
  logic [3:0] exp_reg;
  logic [SPIDP_EV_W-1:0] inten_reg;
  logic [SPIDP_EV_W-1:0] intst_reg;
  logic [1:0] line_reg;
  logic rxovf_reg;
  logic rpt_eff_reg;
  logic [7:0] last_reg;
  logic [3:0] edge_cnt_reg;
  logic [7:0] tx_sh_reg;
  logic [7:0] rx_sh_reg;
  logic sout_reg;
  logic sclk_reg;
  logic [SPIDP_DIV_W-1:0] div_cnt_reg;
  logic sclk_in_q_reg;
  logic sel_q_reg;
  logic irq_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;

  logic acc;
  logic wr;
  logic rd;
  logic [31:0] rdata_next;
  logic hit_next;
  logic active;
  logic ctl;
  logic lsb;
  logic cpha;
  logic tx_push;
  logic tx_pop;
  logic tx_full;
  logic tx_empty;
  logic [7:0] tx_rdata;
  logic rx_push;
  logic rx_pop;
  logic rx_full;
  logic rx_empty;
  logic [9:0] rx_rdata;
  logic [9:0] rx_peek;
  logic [SPIDP_PTR_W:0] rx_count;
  logic [7:0] rx_in;
  logic sin;
  logic [SPIDP_DIV_W-1:0] div_top;
  logic ctl_edge;
  logic tgt_edge;
  logic edge_ev;
  logic sample;
  logic drive;
  logic byte_done;
  logic ctl_start;
  logic sel_fall;
  logic tgt_next;
  logic load;
  logic [7:0] filler;
  logic [7:0] load_byte;
  logic [SPIDP_EV_W-1:0] ev;

  function automatic logic out_bit(input logic [7:0] x, input logic lsb_first);
    out_bit = lsb_first ? x[0] : x[7];
  endfunction

  function automatic logic [7:0] shift_out(input logic [7:0] x, input logic lsb_first);
    shift_out = lsb_first ? {1'b0, x[7:1]} : {x[6:0], 1'b0};
  endfunction

  // APB: one wait state, effects at the edge where pready is high
  assign acc = psel & penable & ~pready_reg;
  assign wr = psel & penable & pready_reg & pwrite;
  assign rd = psel & penable & pready_reg & ~pwrite;

  always_comb begin
    rdata_next = 32'h0000_0000;
    hit_next = 1'b1;
    case (paddr)
      SPIDP_DATA_ADDR: rdata_next[7:0] = rx_rdata[7:0];
      SPIDP_STAT_ADDR: rdata_next[3:0] = {tx_empty & (state_reg == SPIDP_IDLE), ~tx_full, ~rx_empty, rxovf_reg};
      SPIDP_MODE_ADDR: rdata_next[1:0] = mode_reg;
      SPIDP_CFG_ADDR: rdata_next[SPIDP_CFG_W-1:0] = cfg_reg;
      SPIDP_RLIN_ADDR: rdata_next[3:0] = lin_reg;
      SPIDP_REXP_ADDR: rdata_next[3:0] = exp_reg;
      SPIDP_INTST_ADDR: rdata_next[SPIDP_EV_W-1:0] = intst_reg;
      SPIDP_INTEN_ADDR: rdata_next[SPIDP_EV_W-1:0] = inten_reg;
      SPIDP_INTCLR_ADDR: rdata_next = 32'h0000_0000;
      SPIDP_LINE_ADDR: rdata_next[1:0] = line_reg;
      default: hit_next = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= acc;
      pslverr_reg <= acc & ~hit_next;
      if (acc && !pwrite) begin
        prdata_reg <= rdata_next;
      end
    end
  end

  // Software-written configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= SPIDP_CFG_RESET;
      mode_reg <= SPIDP_MODE_RESET;
      lin_reg <= 4'h0;
      exp_reg <= 4'h0;
      inten_reg <= '0;
    end else if (wr) begin
      case (paddr)
        SPIDP_CFG_ADDR: cfg_reg <= pwdata[SPIDP_CFG_W-1:0];
        SPIDP_MODE_ADDR: mode_reg <= pwdata[1:0];
        SPIDP_RLIN_ADDR: lin_reg <= pwdata[3:0];
        SPIDP_REXP_ADDR: exp_reg <= pwdata[3:0];
        SPIDP_INTEN_ADDR: inten_reg <= pwdata[SPIDP_EV_W-1:0];
        default: ;
      endcase
    end
  end

  assign active = (mode_reg == SPIDP_MODE_SPI);
  assign ctl = cfg_reg[SPIDP_CFG_MST];
  assign lsb = cfg_reg[SPIDP_CFG_ORD];
  assign cpha = cfg_reg[SPIDP_CFG_PHA];

  // FIFOs; receive entries carry two line error bits above the byte
  assign tx_push = wr & (paddr == SPIDP_DATA_ADDR);
  assign rx_pop = rd & (paddr == SPIDP_DATA_ADDR);

  spidp_fifo #(.W(8)) u_tx_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .push(tx_push),
    .wdata(pwdata[7:0]),
    .pop(tx_pop),
    .rdata(tx_rdata),
    .peek(),
    .full(tx_full),
    .empty(tx_empty),
    .count()
  );

  spidp_fifo #(.W(10)) u_rx_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .push(rx_push),
    .wdata({2'b00, rx_in}),
    .pop(rx_pop),
    .rdata(rx_rdata),
    .peek(rx_peek),
    .full(rx_full),
    .empty(rx_empty),
    .count(rx_count)
  );

  // Shift engine edge events
  assign div_top = (SPIDP_DIV_W'({16'h0000, lin_reg}) + 20'h00001 << exp_reg) - 20'h00001;
  assign ctl_edge = active & ctl & (state_reg == SPIDP_SHIFT) & ref_tick & (div_cnt_reg == div_top);
  assign tgt_edge = active & ~ctl & ~target_select_n & (state_reg == SPIDP_SHIFT) & (sclk_in != sclk_in_q_reg);
  assign edge_ev = ctl_edge | tgt_edge;
  assign sample = edge_ev & (edge_cnt_reg[0] == cpha);
  assign drive = edge_ev & ~sample & (cpha | (edge_cnt_reg != SPIDP_LAST_EDGE));
  assign byte_done = edge_ev & (edge_cnt_reg == SPIDP_LAST_EDGE);
  assign sin = ctl ? miso_in : mosi_in;
  assign rx_in = lsb ? {sin, rx_sh_reg[7:1]} : {rx_sh_reg[6:0], sin};
  assign rx_push = sample & (edge_cnt_reg >= SPIDP_PUSH_EDGE);

  // Transfer starts and byte selection
  assign ctl_start = active & ctl & (state_reg == SPIDP_IDLE)
                     & (cfg_reg[SPIDP_CFG_RXDRV] ? ~rx_full : ~tx_empty);
  assign sel_fall = active & ~ctl & ~target_select_n & sel_q_reg;
  assign tgt_next = active & ~ctl & ~target_select_n & byte_done;
  assign load = ctl_start | sel_fall | tgt_next;
  assign filler = ((tx_empty && state_reg == SPIDP_IDLE) ? cfg_reg[SPIDP_CFG_RPT] : rpt_eff_reg) ? last_reg
                  : SPIDP_FILLER;
  assign load_byte = (sel_fall || tx_empty) ? filler : tx_rdata;
  assign tx_pop = (ctl_start | tgt_next) & ~tx_empty;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rpt_eff_reg <= 1'b0;
    end else if (tx_empty && state_reg == SPIDP_IDLE) begin
      rpt_eff_reg <= cfg_reg[SPIDP_CFG_RPT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= SPIDP_IDLE;
      edge_cnt_reg <= 4'h0;
    end else if (!active || (!ctl && target_select_n)) begin
      state_reg <= SPIDP_IDLE;
      edge_cnt_reg <= 4'h0;
    end else if (load) begin
      state_reg <= SPIDP_SHIFT;
      edge_cnt_reg <= 4'h0;
    end else if (byte_done) begin
      state_reg <= SPIDP_IDLE;
      edge_cnt_reg <= 4'h0;
    end else if (edge_ev) begin
      edge_cnt_reg <= edge_cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_reg <= SPIDP_LAST_RESET;
      tx_sh_reg <= 8'h00;
      sout_reg <= 1'b0;
    end else if (load) begin
      last_reg <= load_byte;
      if (cpha) begin
        tx_sh_reg <= load_byte;
      end else begin
        sout_reg <= out_bit(load_byte, lsb);
        tx_sh_reg <= shift_out(load_byte, lsb);
      end
    end else if (drive) begin
      sout_reg <= out_bit(tx_sh_reg, lsb);
      tx_sh_reg <= shift_out(tx_sh_reg, lsb);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_sh_reg <= 8'h00;
    end else if (sample) begin
      rx_sh_reg <= rx_in;
    end
  end

  // Controller serial clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_reg <= 1'b0;
      div_cnt_reg <= '0;
    end else if (state_reg != SPIDP_SHIFT || !ctl) begin
      sclk_reg <= cfg_reg[SPIDP_CFG_POL];
      div_cnt_reg <= '0;
    end else if (ctl_edge) begin
      sclk_reg <= ~sclk_reg;
      div_cnt_reg <= '0;
    end else if (ref_tick) begin
      div_cnt_reg <= div_cnt_reg + 20'h00001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_in_q_reg <= 1'b0;
      sel_q_reg <= 1'b1;
    end else begin
      sclk_in_q_reg <= sclk_in;
      sel_q_reg <= target_select_n;
    end
  end

  // Receive overflow and line status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxovf_reg <= 1'b0;
    end else if (rx_push && rx_full) begin
      rxovf_reg <= 1'b1;
    end else if (rx_pop) begin
      rxovf_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_reg <= 2'b00;
    end else if (rx_pop && FIRST_UNIT && mode_reg == SPIDP_MODE_UART) begin
      line_reg <= (rx_count <= (SPIDP_PTR_W+1)'(1)) ? 2'b00 : rx_peek[9:8];
    end
  end

  // Interrupts: sticky status, write-one clear, set wins
  always_comb begin
    ev = '0;
    ev[SPIDP_EV_RXOVF] = rx_push & rx_full;
    ev[SPIDP_EV_TXUND] = load & ~tx_pop;
    ev[SPIDP_EV_RXVAL] = rx_push & rx_empty;
    ev[SPIDP_EV_TXIDLE] = byte_done & tx_empty;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      intst_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      if (wr && paddr == SPIDP_INTCLR_ADDR) begin
        intst_reg <= (intst_reg & ~pwdata[SPIDP_EV_W-1:0]) | ev;
      end else begin
        intst_reg <= intst_reg | ev;
      end
      irq_reg <= |(intst_reg & inten_reg);
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign sclk_out = sclk_reg;
  assign mosi_out = sout_reg;
  assign miso_out = sout_reg;
  assign irq = irq_reg;

endmodule

/* spidp_top_test.sv */
// Testbench for spidp_top in controller role against the partner target, then in target role.
// Assumes ref_tick every fourth pclk and linear prescaler 1.
module spidp_top_test;
  import spidp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ref_tick, sclk_out, mosi_out, miso_in, irq;
  logic sclk_in, mosi_in, target_select_n, p_pol, p_pha, p_lsb, e, miso_out;
  logic [15:0] got;
  logic [31:0] paddr, pwdata, prdata, r;
  logic [7:0] p_tx, p_rx;
  logic [1:0] tc;
  int p_n, nb, n_fail = 0, checks_done = 0;
  // Row: configuration, byte sent, byte the target returns
  logic [23:0] rows [5] = '{24'h10a53c, 24'h14c196, 24'h125ae7, 24'h11380f, 24'h13817e};
  spidp_top spidp_top_i (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .ref_tick, .sclk_out, .mosi_out, .miso_in, .sclk_in, .mosi_in, .target_select_n, .miso_out, .irq);
  spidp_partner spidp_partner_i (.pclk, .sclk(sclk_out), .mosi(mosi_out), .cpol(p_pol), .cpha(p_pha), .lsb(p_lsb),
    .tx_byte(p_tx), .miso(miso_in), .rx_byte(p_rx), .n_bytes(p_n));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    tc <= tc + 2'h1;
    ref_tick <= (tc == 2'h3);
  end
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checks_done++;
    if (g !== x) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      n_fail++;
      tally_and_finish();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_n(input int t);
    for (int k = 0; k < 3000 && p_n < t; k++) @(posedge pclk);
    if (p_n < t) begin
      n_fail++;
      tally_and_finish();
    end
    repeat (4) @(posedge pclk);
  endtask
  // Two bytes as an external controller, mode 0, MSB first; got collects what the block sends
  task automatic tgt_burst(input logic [15:0] m);
    target_select_n <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      mosi_in <= m[15 - i];
      @(posedge pclk);
      @(negedge pclk);
      got = {got[14:0], miso_out};
      @(posedge pclk);
      sclk_in <= 1'b1;
      repeat (2) @(posedge pclk);
      sclk_in <= 1'b0;
    end
    repeat (2) @(posedge pclk);
    target_select_n <= 1'b1;
    @(posedge pclk);
  endtask
  task automatic irq_is(input logic x, input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    repeat (2) @(negedge pclk);
    chk({31'h0, irq}, {31'h0, x});
  endtask
  initial begin
    {psel, penable, pwrite, presetn, ref_tick, sclk_in, mosi_in, p_pol, p_pha, p_lsb} = '0;
    {paddr, pwdata, p_tx, tc} = '0;
    target_select_n = 1'b1;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, SPIDP_CFG_ADDR, 32'h0);
    chk(r, 32'h0);
    apb(1'b0, SPIDP_DATA_ADDR, 32'h0);
    chk(r, 32'h0);
    apb(1'b0, 32'h4000c000, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, SPIDP_CFG_ADDR, 32'hffffffc0);
    apb(1'b0, SPIDP_CFG_ADDR, 32'h0);
    chk(r, 32'h0);
    apb(1'b1, SPIDP_MODE_ADDR, 32'h2);
    apb(1'b1, SPIDP_RLIN_ADDR, 32'h1);
    apb(1'b1, SPIDP_INTEN_ADDR, 32'h1);
    foreach (rows[i]) begin
      {p_lsb, p_pha, p_pol} <= rows[i][18:16];
      p_tx <= rows[i][7:0];
      apb(1'b1, SPIDP_CFG_ADDR, {24'h0, rows[i][23:16]});
      nb = p_n;
      apb(1'b1, SPIDP_DATA_ADDR, {24'h0, rows[i][15:8]});
      wait_n(nb + 1);
      chk({24'h0, p_rx}, {24'h0, rows[i][15:8]});
      apb(1'b0, SPIDP_DATA_ADDR, 32'h0);
      chk(r, {24'h0, rows[i][7:0]});
    end
    {p_lsb, p_pha, p_pol} <= 3'h0;
    p_tx <= 8'h69;
    nb = p_n;
    apb(1'b1, SPIDP_CFG_ADDR, 32'h30);
    wait_n(nb + 4);
    chk({24'h0, p_rx}, {24'h0, SPIDP_FILLER});
    repeat (300) @(posedge pclk);
    chk(32'(p_n), 32'(nb + 4));
    apb(1'b1, SPIDP_CFG_ADDR, 32'h10);
    repeat (4) begin
      apb(1'b0, SPIDP_DATA_ADDR, 32'h0);
      chk(r, 32'h69);
    end
    nb = p_n;
    repeat (5) apb(1'b1, SPIDP_DATA_ADDR, 32'h5c);
    wait_n(nb + 5);
    apb(1'b0, SPIDP_STAT_ADDR, 32'h0);
    chk(r, 32'hf);
    irq_is(1'b0, SPIDP_INTEN_ADDR, 32'h0);
    irq_is(1'b1, SPIDP_INTEN_ADDR, 32'h1);
    irq_is(1'b0, SPIDP_INTCLR_ADDR, 32'h1);
    apb(1'b0, SPIDP_DATA_ADDR, 32'h0);
    chk(r, 32'h69);
    apb(1'b0, SPIDP_STAT_ADDR, 32'h0);
    chk(r, 32'he);
    nb = p_n;
    apb(1'b1, SPIDP_CFG_ADDR, 32'h38);
    wait_n(nb + 1);
    chk({24'h0, p_rx}, 32'h5c);
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, SPIDP_CFG_ADDR, 32'h0);
    chk(r, 32'h0);
    apb(1'b1, SPIDP_MODE_ADDR, 32'h2);
    apb(1'b1, SPIDP_CFG_ADDR, 32'h8);
    tgt_burst(16'h3c96);
    chk({16'h0, got}, {16'h0, SPIDP_LAST_RESET, SPIDP_LAST_RESET});
    apb(1'b1, SPIDP_CFG_ADDR, 32'h0);
    apb(1'b1, SPIDP_DATA_ADDR, 32'ha5);
    tgt_burst(16'h3c96);
    chk({16'h0, got}, {16'h0, SPIDP_FILLER, 8'ha5});
    apb(1'b0, SPIDP_DATA_ADDR, 32'h0);
    chk(r, 32'h3c);
    tally_and_finish();
  end
endmodule
